/* File: dv/plctx_partner.sv */
// Purpose: Upper layer byte source and coded bit sink for the coding chain
// Assumes: Stall choices come from the bench, sampled at the clock edge
// Notes: An idle byte lane toggles every cycle so stale data never looks valid
`timescale 1ns/1ps
module plctx_partner import plctx_pkg::*; (
	input wire logic mclk,
	input wire logic src_stall,
	input wire logic snk_stall,
	output logic in_valid,
	input wire logic in_ready,
	output logic [7:0] in_data,
	input wire logic out_valid,
	output logic out_ready,
	input wire plctx_out_s out_data
);
	logic [7:0] src_q[$];
	plctx_out_s got_q[$];
	logic tk;
	logic ss;
	logic ks;
	// Bytes come already padded by the bench; a raised byte holds until taken
	// One process drives every output, so each has a single driver
	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		out_ready = 1'b0;
		forever begin
			@(posedge mclk);
			tk = in_valid && in_ready;
			ss = src_stall;
			ks = snk_stall;
			if (tk) void'(src_q.pop_front());
			if (out_valid && out_ready) got_q.push_back(out_data);
			#1;
			out_ready = !ks;
			if (tk || !in_valid) begin
				if (src_q.size() > 0 && !ss) begin
					in_valid = 1'b1;
					in_data = src_q[0];
				end else begin
					in_valid = 1'b0;
					in_data = ~in_data;
				end
			end
		end
	end
endmodule // plctx_partner

/* File: dv/tb_top.sv */
// Purpose: Self-checking bench for the transmit coding chain
// Assumes: Expected coded bits come from a reference model written here
// Notes: Config words pack robust, two_blocks, coherent, len and pad
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top import plctx_pkg::*; ;
	logic mclk, reset, ack_start, pay_start, in_valid, in_ready, out_valid, out_ready;
	logic busy, cfg_err, src_stall, snk_stall;
	logic [2:0] rx_dt;
	logic [7:0] in_data;
	plctx_ack_s ack_cfg;
	plctx_cfg_s pay_cfg;
	plctx_out_s out_data;
	int err_total, compares, cyc;
	logic [31:0] rnd, srnd;
	logic [6:0] scr;
	logic [5:0] cv;
	logic [7:0] g[17];
	logic [7:0] pb[$];
	plctx_out_s exp_q[$];
	// Good frames, then refused ones: odd split, empty, too long normal, robust, split
	plctx_cfg_s good[4] = '{24'h00c003, 24'he0a007, 24'h614000, 24'h0ef005};
	plctx_cfg_s bad[5] = '{24'h407000, 24'h000000, 24'h0f0000, 24'h8f8000, 24'h5e0000};
	plctx_chain u_plctx_chain (.mclk(mclk), .reset(reset), .ack_start(ack_start),
		.rx_dt(rx_dt), .ack_cfg(ack_cfg), .pay_start(pay_start), .pay_cfg(pay_cfg),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .busy(busy), .cfg_err(cfg_err));
	plctx_partner u_plctx_partner (.mclk(mclk), .src_stall(src_stall), .snk_stall(snk_stall),
		.in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data));
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) r = {r[6:0], 1'b0} ^ (r[7] ? GF_POLY : 8'h00) ^ (b[i] ? a : 8'h00);
		return r;
	endfunction
	// Scrambler step: taps at stages seven and four
	function logic sb(logic b);
		logic f;
		f = scr[6] ^ scr[3];
		scr = {scr[5:0], f};
		return b ^ f;
	endfunction
	// One encoder input bit gives x repeated rep times, then y repeated rep times
	task cb(logic b, int rep, logic h, logic c);
		logic [6:0] r;
		r = {b, cv};
		cv = r[6:1];
		repeat (rep) exp_q.push_back(plctx_out_s'{^(r & CONV_X), 1'b0, h, c});
		repeat (rep) exp_q.push_back(plctx_out_s'{^(r & CONV_Y), 1'b0, h, c});
	endtask
	task exp_hdr(plctx_ack_s a);
		logic [71:0] h;
		logic [7:0] c;
		h = {a.fcs[7:0], a.ssca, 3'h0, a.nack ? DT_NACK : DT_ACK, 1'b0, 8'h00, a.fcs[15:8], 40'h0};
		c = CRC_SEED;
		for (int i = 71; i >= 14; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? CRC_POLY : 8'h00);
		h[13:6] = ~c;
		scr = SCR_SEED;
		cv = 6'h00;
		for (int i = 71; i >= 0; i--) cb(i >= 6 ? sb(h[i]) : h[i], 6, 1'b1, 1'b0);
		exp_q[exp_q.size()-1].last = 1'b1;
	endtask
	task exp_pay(plctx_cfg_s f, int nb);
		int np, rep, k;
		logic [7:0] m, fb;
		logic [7:0] p[16];
		np = f.robust ? 8 : 16;
		rep = f.robust ? 4 : 1;
		for (int i = 0; i < 17; i++) g[i] = (i == 0) ? 8'h01 : 8'h00;
		m = 8'h01;
		for (int i = 1; i <= np; i++) begin
			m = gm(m, 8'h02);
			for (int j = i; j > 0; j--) g[j] = g[j-1] ^ gm(g[j], m);
			g[0] = gm(g[0], m);
		end
		scr = SCR_SEED;
		k = 0;
		for (int b = 0; b < (f.two_blocks ? 2 : 1); b++) begin
			cv = 6'h00;
			foreach (p[j]) p[j] = 8'h00;
			for (int n = 0; n < nb; n++) begin
				for (int i = 7; i >= 0; i--) m[i] = sb(pb[k][i]);
				k++;
				for (int i = 7; i >= 0; i--) cb(m[i], rep, 1'b0, f.coherent);
				fb = m ^ p[np-1];
				for (int j = np - 1; j > 0; j--) p[j] = p[j-1] ^ gm(fb, g[j]);
				p[0] = gm(fb, g[0]);
			end
			for (int j = np - 1; j >= 0; j--) begin
				for (int i = 7; i >= 0; i--) cb(p[j][i], rep, 1'b0, f.coherent);
			end
			repeat (6) cb(1'b0, rep, 1'b0, f.coherent);
			repeat (f.pad * rep) exp_q.push_back(plctx_out_s'{1'b0, 1'b0, 1'b0, f.coherent});
		end
		exp_q[exp_q.size()-1].last = 1'b1;
	endtask
	task ack(logic [2:0] dt, plctx_ack_s a);
		@(posedge mclk);
		#1;
		ack_start = 1'b1;
		rx_dt = dt;
		ack_cfg = a;
		@(posedge mclk);
		#1;
		ack_start = 1'b0;
		rx_dt = ~dt;
		ack_cfg = ~a;
	endtask
	task pay(plctx_cfg_s f);
		@(posedge mclk);
		#1;
		pay_start = 1'b1;
		pay_cfg = f;
		@(posedge mclk);
		#1;
		pay_start = 1'b0;
		pay_cfg = ~f;
	endtask
	task wait_frame();
		int t;
		t = 0;
		while ((busy !== 1'b0 || u_plctx_partner.got_q.size() < exp_q.size()) && t < 40000) begin
			@(posedge mclk);
			t++;
		end
		repeat (4) @(posedge mclk);
		`CHK("bit count", exp_q.size(), u_plctx_partner.got_q.size())
		foreach (exp_q[i]) if (i < u_plctx_partner.got_q.size())
			`CHK("coded bit", exp_q[i], u_plctx_partner.got_q[i])
		exp_q.delete();
		u_plctx_partner.got_q.delete();
	endtask
	task complete_run();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Random stalls on both sides of the chain
	always @(posedge mclk) begin
		#1;
		srnd = lfsr(srnd);
		src_stall = srnd[2];
		snk_stall = (srnd[1:0] == 2'b00);
	end
	// Cut a hang short well past the longest expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 95000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		{ack_start, pay_start, src_stall, snk_stall, rx_dt} = '0;
		ack_cfg = '0;
		pay_cfg = '0;
		reset = 1'b1;
		rnd = 32'hf4f97a48;
		srnd = rnd;
		{err_total, compares, cyc} = '0;
		repeat (2) @(posedge mclk);
		#1 reset = 1'b0;
		ack(DT_ACK, 18'h01234);
		`CHK("busy", 1'b0, busy)
		for (int s = 0; s < 4; s++) begin
			rnd = lfsr(rnd);
			exp_hdr({s[0], s[1], rnd[15:0]});
			ack(DT_RX_ANSWER, {s[0], s[1], rnd[15:0]});
			// Starts during a header are ignored, good or bad
			pay(good[0]);
			`CHK("busy hold", 1'b1, busy)
			pay(bad[1]);
			`CHK("cfg_err busy", 1'b0, cfg_err)
			wait_frame();
		end
		foreach (good[c]) begin
			pb.delete();
			repeat (good[c].len) begin
				rnd = lfsr(rnd);
				pb.push_back(rnd[7:0]);
				u_plctx_partner.src_q.push_back(rnd[7:0]);
			end
			exp_pay(good[c], good[c].two_blocks ? good[c].len / 2 : good[c].len);
			pay(good[c]);
			wait_frame();
		end
		foreach (bad[c]) begin
			pay(bad[c]);
			`CHK("cfg_err", 1'b1, cfg_err)
			@(posedge mclk);
			#1;
			`CHK("cfg_err low", 1'b0, cfg_err)
			`CHK("busy refused", 1'b0, busy)
		end
		complete_run();
	end
endmodule // tb_top

/* File: src/plctx_chain.sv */
// Purpose: Header build, CRC, scrambler, RS, convolutional and repetition coding
// Assumes: Upper layer pads the payload and gives pad bit count per block
// Notes: Output is one coded bit per handshake through a two-entry buffer
// Functional notes
// - Acknowledgement header only sent after a received frame with delimiter type 1.
// - Header byte 1 bit 7 carries the further-segments flag.
// - Header byte 1 bits 3..1 hold type: 2 for ACK, 3 for NACK.
// - FCS low byte in byte 0, high in byte 3, reserved zero, six conv zeros.
// - Header CRC8 covers first 58 bits, register preset to all ones.
// - CRC generator x^8+x^2+x+1, fed MSB of byte 0 first.
// - Inverted CRC bits 7..2 in byte 7 bits 5..0, bits 1..0 in byte 8.
// - Payload bytes enter the scrambler one bit at a time, MSB first.
// - Scrambler XORs data with PN from x^7+x^4+1.
// - Scrambler loaded with ones at header start and payload start.
// - Payload is RS then convolutional; robust repeats by four, header by six.
// - RS over bytes: normal 16 parity bytes, robust 8 parity bytes per block.
// - GF(256) polynomial x^8+x^4+x^3+x^2+1, generator roots alpha^1..alpha^2T.
// - First scrambled bit is the MSB of each RS input symbol.
// - Zero fill implied and dropped; message then parity, MSB first.
// - Rate one half, constraint seven, taps 1111001 and 1011011.
// - Six zero tail bits return the encoder to the zero state.
// - Zero pad bits follow convolutional output, before repetition.
// - Two blocks are equal halves, each within 255 bytes, padded separately.
// - Split after scrambling; each block RS, conv, repeated and padded alone.
// - No sequence restart marker between the two blocks of one frame.
// - Four-fold repetition only in robust mode; modulation follows scheme flag.
// - Six-fold repetition only for header, no RS, always differential.
`timescale 1ns/1ps
module plctx_chain import plctx_pkg::*; (
	input wire logic mclk,
	input wire logic reset,
	input wire logic ack_start,
	input wire logic [2:0] rx_dt,
	input wire plctx_ack_s ack_cfg,
	input wire logic pay_start,
	input wire plctx_cfg_s pay_cfg,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output plctx_out_s out_data,
	output logic busy,
	output logic cfg_err
);
	typedef struct packed {
		plctx_ph_e ph;
		logic hdr_frame;
		logic [57:0] hdr;
		logic [7:0] crc;
		logic [6:0] scr;
		logic [5:0] cs;
		logic [6:0] idx;
		logic [7:0] sbyte;
		logic have;
		logic [2:0] bitn;
		logic [8:0] cnt;
		logic [8:0] blk_len;
		logic blk2;
		plctx_par_t par;
		plctx_cfg_s cfg;
		logic [1:0] pair;
		logic nb2;
		logic emit;
		logic lastp;
		logic [2:0] rmax;
		logic e_bit;
		logic [2:0] e_rep;
		logic [11:0] padcnt;
		plctx_out_s [1:0] fifo;
		logic wp;
		logic rp;
		logic [1:0] fcnt;
		logic err;
	} plctx_st_s;

	plctx_st_s q;
	plctx_st_s n;
	logic step;
	logic raw;
	logic sfb;
	logic [6:0] win;
	logic space;
	logic pop;
	logic [14:0] sb;
	logic [7:0] fb;
	logic [8:0] len;
	logic [8:0] half;
	logic [4:0] roots;
	logic block_end;
	logic more_blk;

	// Scramble one byte, MSB first, returning {new state, byte}
	function automatic logic [14:0] scr_byte(logic [6:0] s, logic [7:0] d);
		logic [6:0] st;
		logic [7:0] o;
		logic f;
		st = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			f = st[6] ^ st[3];
			o[i] = d[i] ^ f;
			st = {st[5:0], f};
		end
		return {st, o};
	endfunction

	// Handshake and status outputs come straight from the state register
	assign space = q.fcnt != 2'h2;
	assign pop = out_ready && q.fcnt != 2'h0;
	assign out_valid = q.fcnt != 2'h0;
	assign out_data = q.fifo[q.rp];
	// Busy also covers the last pair still being repeated, so a new start
	// cannot retune the repetition count or frame flags under it
	assign busy = q.ph != PH_IDLE || q.emit;
	assign cfg_err = q.err;
	assign in_ready = q.ph == PH_MSG && !q.have && !q.emit;
	assign len = pay_cfg.len;
	assign half = pay_cfg.two_blocks ? {1'b0, len[8:1]} : len;
	assign roots = pay_cfg.robust ? ROOTS_ROBUST : ROOTS_NORMAL;
	assign more_blk = q.cfg.two_blocks && !q.blk2;

	// Next state: command start, bit source, encoder, repetition, buffer
	always_comb begin
		n = q;
		n.err = 1'b0;
		raw = 1'b0;
		sfb = q.scr[6] ^ q.scr[3];
		sb = scr_byte(q.scr, in_data);
		fb = 8'h00;
		block_end = 1'b0;
		step = !q.emit && q.ph != PH_IDLE && q.ph != PH_PAD
			&& !(q.ph == PH_MSG && !q.have);
		win = 7'h00;
		// Starts are taken only once no coded pair of the last frame is pending
		if (!busy) begin
			if (ack_start && rx_dt == DT_RX_ANSWER) begin
				n.ph = PH_HDR;
				n.hdr_frame = 1'b1;
				n.hdr = {ack_cfg.fcs[7:0], ack_cfg.ssca, 3'h0,
					ack_cfg.nack ? DT_NACK : DT_ACK, 1'b0, 8'h00,
					ack_cfg.fcs[15:8], 24'h000000, 2'h0};
				n.crc = CRC_SEED;
				n.scr = SCR_SEED;
				n.cs = 6'h00;
				n.idx = 7'h00;
				n.rmax = REP_HDR;
			end else if (pay_start) begin
				if (len == 9'h000 || (pay_cfg.two_blocks && len[0])
					|| ({1'b0, half} + {5'h00, roots} > 10'(RS_N))) begin
					n.err = 1'b1;
				end else begin
					n.ph = PH_MSG;
					n.hdr_frame = 1'b0;
					n.cfg = pay_cfg;
					n.blk_len = half;
					n.blk2 = 1'b0;
					n.scr = SCR_SEED;
					n.cs = 6'h00;
					n.par = '0;
					n.cnt = 9'h000;
					n.have = 1'b0;
					n.bitn = 3'h0;
					n.rmax = pay_cfg.robust ? REP_ROBUST : REP_NORMAL;
				end
			end
		end
		// Byte intake: scramble, then run the parity register on the scrambled byte
		if (in_ready && in_valid) begin
			n.scr = sb[14:8];
			n.sbyte = sb[7:0];
			n.have = 1'b1;
			fb = sb[7:0] ^ q.par[15];
			for (int j = 15; j > 0; j--) begin
				n.par[j] = q.par[j-1] ^ gf_mul(fb, q.cfg.robust ? RS_G_ROBUST[j] : RS_G_NORMAL[j]);
			end
			n.par[0] = gf_mul(fb, q.cfg.robust ? RS_G_ROBUST[0] : RS_G_NORMAL[0]);
		end
		// One encoder input bit per step
		if (step) begin
			unique case (q.ph)
				PH_HDR: begin
					if (q.idx < 7'(HDR_DATA_BITS)) begin
						raw = q.hdr[57];
						n.hdr = {q.hdr[56:0], 1'b0};
						n.crc = {q.crc[6:0], 1'b0} ^ ((q.crc[7] ^ raw) ? CRC_POLY : 8'h00);
					end else if (q.idx < 7'(HDR_CRC_END)) begin
						raw = ~q.crc[7];
						n.crc = {q.crc[6:0], 1'b0};
					end
					if (q.idx < 7'(HDR_CRC_END)) begin
						raw = raw ^ sfb;
						n.scr = {q.scr[5:0], sfb};
					end
					n.idx = q.idx + 7'h01;
					if (q.idx == 7'(HDR_BITS - 1)) begin
						n.ph = PH_IDLE;
						n.lastp = 1'b1;
					end else begin
						n.lastp = 1'b0;
					end
				end
				PH_MSG: begin
					raw = q.sbyte[7];
					n.sbyte = {q.sbyte[6:0], 1'b0};
					n.bitn = q.bitn + 3'h1;
					n.lastp = 1'b0;
					if (q.bitn == 3'h7) begin
						n.have = 1'b0;
						n.cnt = q.cnt + 9'h001;
						if (q.cnt == q.blk_len - 9'h001) begin
							n.ph = PH_PAR;
							n.cnt = 9'h000;
						end
					end
				end
				PH_PAR: begin
					raw = q.par[15][7];
					n.par = {q.par[15][6:0], q.par[14:0], 1'b0};
					n.cnt = q.cnt + 9'h001;
					n.lastp = 1'b0;
					if (q.cnt == {1'b0, (q.cfg.robust ? ROOTS_ROBUST : ROOTS_NORMAL), 3'h0} - 9'h001) begin
						n.ph = PH_TAIL;
						n.idx = 7'h00;
					end
				end
				PH_TAIL: begin
					raw = 1'b0;
					n.idx = q.idx + 7'h01;
					n.lastp = 1'b0;
					if (q.idx == 7'(TAIL_BITS - 1)) begin
						n.padcnt = 12'h000;
						if (q.cfg.pad == 12'h000) begin
							block_end = 1'b1;
						end else begin
							n.ph = PH_PAD;
						end
					end
				end
				default: begin
					n.lastp = 1'b0;
				end
			endcase
			win = {raw, q.cs};
			n.cs = win[6:1];
			n.pair = {^(win & CONV_X), ^(win & CONV_Y)};
			n.nb2 = 1'b1;
			n.emit = 1'b1;
			n.e_bit = 1'b0;
			n.e_rep = 3'h0;
		end
		// Pad bits leave the encoder untouched and are repeated like coded bits
		if (!q.emit && q.ph == PH_PAD) begin
			n.pair = 2'h0;
			n.nb2 = 1'b0;
			n.emit = 1'b1;
			n.e_bit = 1'b1;
			n.e_rep = 3'h0;
			n.padcnt = q.padcnt + 12'h001;
			n.lastp = 1'b0;
			if (q.padcnt == q.cfg.pad - 12'h001) begin
				block_end = 1'b1;
			end
		end
		// Second block keeps scrambler and frame going, clears coder state
		if (block_end) begin
			if (more_blk) begin
				n.ph = PH_MSG;
				n.blk2 = 1'b1;
				n.cs = 6'h00;
				n.par = '0;
				n.cnt = 9'h000;
				n.bitn = 3'h0;
				n.have = 1'b0;
			end else begin
				n.ph = PH_IDLE;
				n.lastp = 1'b1;
			end
		end
		// Repetition: each coded bit is pushed rmax times before the next
		// A full buffer refuses the push even when a pop frees a slot; this costs
		// a cycle now and then but keeps the occupancy count simple
		if (q.emit && space) begin
			n.fifo[q.wp] = '{data: q.e_bit ? q.pair[0] : q.pair[1],
				last: q.lastp && q.e_bit && q.e_rep == q.rmax - 3'h1,
				hdr: q.hdr_frame, coherent: !q.hdr_frame && q.cfg.coherent};
			n.wp = !q.wp;
			n.e_rep = q.e_rep + 3'h1;
			if (q.e_rep == q.rmax - 3'h1) begin
				n.e_rep = 3'h0;
				n.e_bit = 1'b1;
				if (q.e_bit) n.emit = 1'b0;
			end
		end
		if (pop) n.rp = !q.rp;
		n.fcnt = q.fcnt + {1'b0, q.emit && space} - {1'b0, pop};
	end

	// Single state register; the whole state clears on reset
	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// Steps that hand the final header bit or tail bit to the encoder
	sequence s_hdr_last;
		step && q.ph == PH_HDR && q.idx == 7'(HDR_BITS - 1);
	endsequence
	sequence s_tail_last;
		step && q.ph == PH_TAIL && q.idx == 7'(TAIL_BITS - 1);
	endsequence

	ack_gate_a: assert property (@(posedge mclk) disable iff (reset)
		q.ph == PH_IDLE && !ack_start && !pay_start |=> q.ph == PH_IDLE)
		else $error("frame started without a request");
	hdr_type_a: assert property (@(posedge mclk) disable iff (reset)
		!busy && ack_start && rx_dt == DT_RX_ANSWER
		|=> q.hdr[45:43] == ($past(ack_cfg.nack) ? DT_NACK : DT_ACK)
		&& q.hdr[49] == $past(ack_cfg.ssca))
		else $error("header type or segment flag wrong");
	hdr_seed_a: assert property (@(posedge mclk) disable iff (reset)
		!busy && ack_start && rx_dt == DT_RX_ANSWER
		|=> q.crc == CRC_SEED && q.scr == SCR_SEED && q.cs == 6'h00)
		else $error("header seeds not loaded");
	hdr_len_a: assert property (@(posedge mclk) disable iff (reset)
		s_hdr_last |=> q.ph == PH_IDLE && q.emit && q.lastp && q.rmax == REP_HDR)
		else $error("header length wrong");
	tail_zero_a: assert property (@(posedge mclk) disable iff (reset)
		s_tail_last |=> q.cs == 6'h00)
		else $error("encoder not flushed by tail");
	rep_count_a: assert property (@(posedge mclk) disable iff (reset)
		q.emit && space && q.e_rep == q.rmax - 3'h1 && q.e_bit |=> !q.emit)
		else $error("repetition count wrong");
	byte_in_a: assert property (@(posedge mclk) disable iff (reset)
		in_ready && in_valid |=> q.have && !in_ready ##1 !in_ready[*7])
		else $error("byte not held for eight bits");
	buf_hold_a: assert property (@(posedge mclk) disable iff (reset)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffer lost a stalled bit");
	par_len_a: assert property (@(posedge mclk) disable iff (reset)
		$rose(q.ph == PH_TAIL) |-> $past(q.cnt) == {1'b0,
		(q.cfg.robust ? ROOTS_ROBUST : ROOTS_NORMAL), 3'h0} - 9'h001)
		else $error("parity length wrong");

	// Payload start seen by an idle chain, accepted or refused
	sequence s_pay_go;
		!busy && pay_start && !(ack_start && rx_dt == DT_RX_ANSWER);
	endsequence
	// Final step that shifts out the inverted check value
	sequence s_crc_last;
		step && q.ph == PH_HDR && q.idx == 7'(HDR_CRC_END - 1);
	endsequence

	// Payload seeding, refusal, block restart, padding and output flags
	pay_seed_a: assert property (@(posedge mclk) disable iff (reset)
		s_pay_go |=> cfg_err || (q.scr == SCR_SEED && q.cs == 6'h00 && q.par == '0))
		else $error("payload seeds not loaded");
	pay_refuse_a: assert property (@(posedge mclk) disable iff (reset)
		s_pay_go ##1 cfg_err |-> !busy)
		else $error("refused start left the chain busy");
	blk_clear_a: assert property (@(posedge mclk) disable iff (reset)
		block_end && more_blk |=> q.ph == PH_MSG && q.cs == 6'h00 && q.par == '0)
		else $error("second block started with stale coder state");
	pad_zero_a: assert property (@(posedge mclk) disable iff (reset)
		q.emit && !q.nb2 |-> q.e_bit && q.pair == 2'h0)
		else $error("pad bit not zero");
	hdr_diff_a: assert property (@(posedge mclk) disable iff (reset)
		out_valid && out_data.hdr |-> !out_data.coherent)
		else $error("header bit marked coherent");
	rep_mode_a: assert property (@(posedge mclk) disable iff (reset)
		q.ph != PH_IDLE && !q.hdr_frame |-> q.rmax == (q.cfg.robust ? REP_ROBUST : REP_NORMAL))
		else $error("repetition factor does not follow mode");
	drain_hold_a: assert property (@(posedge mclk) disable iff (reset)
		q.emit && q.ph == PH_IDLE |=> q.ph == PH_IDLE)
		else $error("frame started while a pair was still repeated");
	crc_flush_a: assert property (@(posedge mclk) disable iff (reset)
		s_crc_last |=> q.crc == 8'h00)
		else $error("inverted check value not fully sent");
endmodule // plctx_chain

/* File: src/plctx_pkg.sv */
// Purpose: Shared types and constants for the transmit coding chain
// Assumes: GF(256) with field polynomial 0x11d, alpha = 2
// Notes: Reed-Solomon generator coefficients are worked out at elaboration
package plctx_pkg;
	localparam int HDR_DATA_BITS = 58;
	localparam int HDR_CRC_END = 66;
	localparam int HDR_BITS = 72;
	localparam int TAIL_BITS = 6;
	localparam int RS_N = 255;
	localparam logic [7:0] CRC_SEED = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] GF_POLY = 8'h1d;
	localparam logic [6:0] SCR_SEED = 7'h7f;
	localparam logic [6:0] CONV_X = 7'h79;
	localparam logic [6:0] CONV_Y = 7'h5b;
	localparam logic [2:0] DT_RX_ANSWER = 3'h1;
	localparam logic [2:0] DT_ACK = 3'h2;
	localparam logic [2:0] DT_NACK = 3'h3;
	localparam logic [2:0] REP_HDR = 3'h6;
	localparam logic [2:0] REP_ROBUST = 3'h4;
	localparam logic [2:0] REP_NORMAL = 3'h1;
	localparam logic [4:0] ROOTS_NORMAL = 5'h10;
	localparam logic [4:0] ROOTS_ROBUST = 5'h08;

	typedef logic [15:0][7:0] plctx_par_t;
	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_HDR = 3'b001,
		PH_MSG = 3'b010,
		PH_PAR = 3'b011,
		PH_TAIL = 3'b100,
		PH_PAD = 3'b101
	} plctx_ph_e;
	typedef struct packed {
		logic ssca;
		logic nack;
		logic [15:0] fcs;
	} plctx_ack_s;
	typedef struct packed {
		logic robust;
		logic two_blocks;
		logic coherent;
		logic [8:0] len;
		logic [11:0] pad;
	} plctx_cfg_s;
	typedef struct packed {
		logic data;
		logic last;
		logic hdr;
		logic coherent;
	} plctx_out_s;

	function automatic logic [7:0] gf_mul(logic [7:0] a, logic [7:0] b);
		logic [7:0] p;
		logic [7:0] t;
		p = 8'h00;
		t = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i]) p = p ^ t;
			t = t[7] ? ({t[6:0], 1'b0} ^ GF_POLY) : {t[6:0], 1'b0};
		end
		return p;
	endfunction

	// Coefficients g0..g(n-1) of prod (x - alpha^i), placed from byte offset off
	function automatic plctx_par_t rs_gen(int n, int off);
		logic [16:0][7:0] g;
		plctx_par_t r;
		logic [7:0] root;
		g = '0;
		r = '0;
		g[0] = 8'h01;
		root = 8'h01;
		for (int i = 1; i <= n; i++) begin
			root = gf_mul(root, 8'h02);
			for (int j = i; j > 0; j--) g[j] = g[j-1] ^ gf_mul(g[j], root);
			g[0] = gf_mul(g[0], root);
		end
		for (int j = 0; j < n; j++) r[j+off] = g[j];
		return r;
	endfunction

	localparam plctx_par_t RS_G_NORMAL = rs_gen(16, 0);
	localparam plctx_par_t RS_G_ROBUST = rs_gen(8, 8);
endpackage
